//--- verilog/cswm_consts.vh
// Constants for the CAN selective-wake mode control block
`ifndef CSWM_CONSTS_VH
`define CSWM_CONSTS_VH
`define CSWM_OFS_CHIP 4'h0
`define CSWM_OFS_CAN 4'h4
`define CSWM_OFS_STAT 4'h8
`define CSWM_OFS_STATE 4'hC
`define CSWM_CHIP_NORMAL 2'h0
`define CSWM_CHIP_STOP 2'h1
`define CSWM_CHIP_SLEEP 2'h2
`define CSWM_CHIP_RESTART 2'h3
`define CSWM_TRX_OFF 2'h0
`define CSWM_TRX_WAKE 2'h1
`define CSWM_TRX_RX 2'h2
`define CSWM_TRX_NORMAL 2'h3
`define CSWM_MODE_RST 3'h0
`define CSWM_MODE_SWK 3'h5
`define CSWM_LOW_WAKE 2'h1
`define CSWM_BIT_ERR 0
`define CSWM_BIT_ARMED 1
`define CSWM_BIT_SIL 2
`define CSWM_BIT_CFGV 3
`define CSWM_BIT_WAKE 4
`define CSWM_BIT_WF 5
`define CSWM_BIT_WP 6
`define CSWM_BIT_WOKEN 7
`define CSWM_RESP_OKAY 2'h0
`define CSWM_RESP_SLVERR 2'h2
`endif

//--- verilog/cswm_trx_decode.v
// Decoder from chip mode, CAN mode field and flags to the actual transceiver mode
`timescale 1ns/100ps
`include "cswm_consts.vh"
module cswm_trx_decode
(
    input wire [1:0] chip_mode,
    input wire [2:0] can_mode,
    input wire swk_error_flag,
    input wire woken,
    output reg [1:0] trx_mode,
    output reg selective_wake
);
    always @*
    begin
        trx_mode = `CSWM_TRX_OFF;
        selective_wake = 1'b0;
        if (can_mode[1:0] == 2'h0)
        begin
            trx_mode = `CSWM_TRX_OFF;
        end
        else if (chip_mode == `CSWM_CHIP_RESTART)
        begin
            trx_mode = `CSWM_TRX_WAKE;
        end
        else if (chip_mode != `CSWM_CHIP_NORMAL && woken)
        begin
            trx_mode = `CSWM_TRX_WAKE;
        end
        else if (chip_mode == `CSWM_CHIP_STOP && can_mode == 3'h3)
        begin
            trx_mode = `CSWM_TRX_WAKE;
        end
        else
        begin
            trx_mode = can_mode[1:0];
            // Error flag keeps bit 2 but drops frame detection
            selective_wake = can_mode[2] & ~swk_error_flag;
        end
    end
endmodule

//--- verilog/cswm_top.v
// CAN selective-wake mode control with AXI4-Lite register access
// Operation
// - Mode field writes are ignored outside normal chip mode.
// - Bit 2 selects selective wake; 000/100 off, 001 wake, 010 rx, 011 normal.
// - 101 wake, 110 receive only, 111 normal, each with selective wake.
// - Normal with selective wake passes data and runs the silence monitor.
// - Wake frame in normal mode raises wake event, receive output untouched.
// - Receive only with selective wake delivers data, never drives the bus.
// - Error flag is clear only while selective wake works without overflow.
// - Mode field reads back the programmed mode; status shows actual state.
// - Stop keeps fields; 011 runs wake only; error flag drops selective wake.
// - Error flag blocks wake frames and leaves mode bit 2 alone.
// - Sleep rewrites 010/011 to 001 and 110/111 to 101.
// - Wake frame in sleep enters restart, clears config valid, keeps 101.
// - Sleep entry rearms a woken transceiver automatically.
// - An off mode stays off in sleep.
// - Armed flag clears on any wake and when mode bit 2 clears.
// - Error flag sets on config failure or overflow in selective-wake modes.
// - Restart keeps off modes, others fall back to plain wake capable.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "cswm_consts.vh"
module cswm_top
(
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire txd,
    input wire bus_rxd,
    output reg rxd,
    output reg bus_tx_dominant,
    input wire wake_frame_det,
    input wire wake_pattern_det,
    input wire err_count_overflow,
    input wire bus_silence_det,
    output reg swk_monitor_en,
    output reg can_wake_event
);
    reg [1:0] chip_mode;
    reg [2:0] can_mode;
    reg swk_error_flag;
    reg swk_armed_flag;
    reg bus_silence_flag;
    reg swk_config_valid;
    reg can_wake;
    reg wake_frame;
    reg wake_pattern;
    reg woken;
    reg aw_got;
    reg w_got;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire [1:0] trx_mode;
    wire selective_wake;
    wire wr_fire;
    wire wr_ok;
    wire rd_fire;
    wire [7:0] wb;
    wire low_power;
    wire frame_hit;
    wire pattern_hit;
    wire overflow_hit;
    wire any_wake;
    wire mode_wr;
    wire cfg_fail;
    wire w1c_err;
    wire w1c_sil;
    wire w1c_wake;
    reg [2:0] next_can_mode;
    reg [1:0] next_chip_mode;

    // Mode field selects selective wake at all
    function swk_mode;
        input [2:0] m;
        begin
            swk_mode = m[2] & (m[1:0] != 2'h0);
        end
    endfunction

    function mapped;
        input [3:0] a;
        begin
            mapped = (a == `CSWM_OFS_CHIP) || (a == `CSWM_OFS_CAN) ||
                (a == `CSWM_OFS_STAT) || (a == `CSWM_OFS_STATE);
        end
    endfunction

    cswm_trx_decode u_dec
    (
        .chip_mode(chip_mode),
        .can_mode(can_mode),
        .swk_error_flag(swk_error_flag),
        .woken(woken),
        .trx_mode(trx_mode),
        .selective_wake(selective_wake)
    );

    // Address and data are taken independently and held until the write lands
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
    assign wr_ok = wr_fire & mapped(aw_addr) & w_strb[0];
    assign rd_fire = s_axi_arvalid & ~s_axi_rvalid;
    assign wb = w_data[7:0];

    assign low_power = (chip_mode == `CSWM_CHIP_STOP) || (chip_mode == `CSWM_CHIP_SLEEP);
    assign frame_hit = wake_frame_det & selective_wake & ~woken;
    assign pattern_hit = wake_pattern_det & low_power & ~woken & ~selective_wake &
        (trx_mode == `CSWM_TRX_WAKE);
    assign overflow_hit = err_count_overflow & selective_wake & ~woken;
    assign any_wake = frame_hit | pattern_hit | overflow_hit;

    assign mode_wr = wr_ok & (aw_addr == `CSWM_OFS_CAN) &
        (chip_mode == `CSWM_CHIP_NORMAL);
    // Selecting selective wake without valid configuration fails the check
    assign cfg_fail = mode_wr & swk_mode(wb[2:0]) & ~swk_config_valid;
    assign w1c_err = wr_ok & (aw_addr == `CSWM_OFS_STAT) & wb[`CSWM_BIT_ERR];
    assign w1c_sil = wr_ok & (aw_addr == `CSWM_OFS_STAT) & wb[`CSWM_BIT_SIL];
    assign w1c_wake = wr_ok & (aw_addr == `CSWM_OFS_STAT) & wb[`CSWM_BIT_WAKE];

    // Chip mode sequencing and the mode field rewrite on going from normal mode to sleep
    always @*
    begin
        next_chip_mode = chip_mode;
        next_can_mode = can_mode;
        if (mode_wr)
        begin
            next_can_mode = wb[2:0];
        end
        if (chip_mode == `CSWM_CHIP_SLEEP && any_wake)
        begin
            next_chip_mode = `CSWM_CHIP_RESTART;
        end
        else if (wr_ok && aw_addr == `CSWM_OFS_CHIP)
        begin
            case (chip_mode)
                `CSWM_CHIP_NORMAL:
                begin
                    if (wb[1:0] == `CSWM_CHIP_STOP)
                    begin
                        next_chip_mode = `CSWM_CHIP_STOP;
                    end
                    else if (wb[1:0] == `CSWM_CHIP_SLEEP)
                    begin
                        next_chip_mode = `CSWM_CHIP_SLEEP;
                        if (can_mode[1])
                        begin
                            next_can_mode = {can_mode[2], `CSWM_LOW_WAKE};
                        end
                    end
                end
                `CSWM_CHIP_STOP,
                `CSWM_CHIP_RESTART:
                begin
                    if (wb[1:0] == `CSWM_CHIP_NORMAL)
                    begin
                        next_chip_mode = `CSWM_CHIP_NORMAL;
                    end
                end
                default:
                begin
                    next_chip_mode = chip_mode;
                end
            endcase
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chip_mode <= `CSWM_CHIP_NORMAL;
            can_mode <= `CSWM_MODE_RST;
            swk_error_flag <= 1'b0;
            swk_armed_flag <= 1'b0;
            bus_silence_flag <= 1'b0;
            swk_config_valid <= 1'b0;
            can_wake <= 1'b0;
            wake_frame <= 1'b0;
            wake_pattern <= 1'b0;
            woken <= 1'b0;
            can_wake_event <= 1'b0;
        end
        else if (ce)
        begin
            chip_mode <= next_chip_mode;
            can_mode <= next_can_mode;
            can_wake_event <= any_wake;
            // Set terms come last so an event in the clearing cycle survives
            if (w1c_err)
            begin
                swk_error_flag <= 1'b0;
            end
            if (cfg_fail || overflow_hit)
            begin
                swk_error_flag <= 1'b1;
            end
            if (w1c_sil)
            begin
                bus_silence_flag <= 1'b0;
            end
            if (bus_silence_det && selective_wake && !woken)
            begin
                bus_silence_flag <= 1'b1;
            end
            if (w1c_wake)
            begin
                can_wake <= 1'b0;
            end
            if (any_wake)
            begin
                can_wake <= 1'b1;
            end
            if (wr_ok && aw_addr == `CSWM_OFS_STAT && wb[`CSWM_BIT_CFGV])
            begin
                swk_config_valid <= 1'b1;
            end
            if (chip_mode == `CSWM_CHIP_SLEEP && frame_hit)
            begin
                swk_config_valid <= 1'b0;
            end
            // A rewrite to another value is the host's rearm
            if (mode_wr && wb[2:0] != can_mode)
            begin
                woken <= 1'b0;
                wake_frame <= 1'b0;
                wake_pattern <= 1'b0;
            end
            if (next_chip_mode == `CSWM_CHIP_SLEEP && chip_mode == `CSWM_CHIP_NORMAL)
            begin
                woken <= 1'b0;
                wake_frame <= 1'b0;
                wake_pattern <= 1'b0;
            end
            if (any_wake)
            begin
                woken <= 1'b1;
            end
            if (frame_hit)
            begin
                wake_frame <= 1'b1;
            end
            if (pattern_hit)
            begin
                wake_pattern <= 1'b1;
            end
            if (mode_wr && swk_mode(wb[2:0]) && swk_config_valid && !swk_error_flag)
            begin
                swk_armed_flag <= 1'b1;
            end
            if (next_chip_mode == `CSWM_CHIP_SLEEP && chip_mode == `CSWM_CHIP_NORMAL &&
                swk_mode(can_mode) && !swk_error_flag)
            begin
                swk_armed_flag <= 1'b1;
            end
            // Clearing wins here: a wake ends the armed state by definition
            if (any_wake || !next_can_mode[2] || cfg_fail)
            begin
                swk_armed_flag <= 1'b0;
            end
        end
    end

    // Bus path; a woken transceiver in low power signals by a low receive output
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxd <= 1'b1;
            bus_tx_dominant <= 1'b0;
            swk_monitor_en <= 1'b0;
        end
        else if (ce)
        begin
            swk_monitor_en <= selective_wake & ~woken;
            bus_tx_dominant <= (trx_mode == `CSWM_TRX_NORMAL) & ~txd;
            if (trx_mode == `CSWM_TRX_NORMAL || trx_mode == `CSWM_TRX_RX)
            begin
                rxd <= bus_rxd;
            end
            else if (woken && low_power)
            begin
                rxd <= 1'b0;
            end
            else
            begin
                rxd <= 1'b1;
            end
        end
    end

    // AXI4-Lite write channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSWM_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? `CSWM_RESP_OKAY : `CSWM_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CSWM_RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped({s_axi_araddr[3:2], 2'h0}) ?
                    `CSWM_RESP_OKAY : `CSWM_RESP_SLVERR;
                case ({s_axi_araddr[3:2], 2'h0})
                    `CSWM_OFS_CHIP: s_axi_rdata <= {30'h0, chip_mode};
                    `CSWM_OFS_CAN: s_axi_rdata <= {29'h0, can_mode};
                    `CSWM_OFS_STAT: s_axi_rdata <= {24'h0, woken, wake_pattern, wake_frame,
                        can_wake, swk_config_valid, bus_silence_flag, swk_armed_flag,
                        swk_error_flag};
                    `CSWM_OFS_STATE: s_axi_rdata <= {29'h0, selective_wake, trx_mode};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- sim/cswm_bus_node.sv
// Far-side model: CAN bus level and frame decoder event pulses
`timescale 1ns/100ps
module cswm_bus_node
(
    input wire aclk,
    output wire bus_rxd,
    output wire wake_frame_det,
    output wire wake_pattern_det,
    output wire err_count_overflow,
    output wire bus_silence_det
);
    // Recessive while no node drives the bus
    reg rx_level = 1'b1;
    reg [3:0] ev = 4'h0;
    assign bus_rxd = rx_level;
    assign {bus_silence_det, err_count_overflow, wake_pattern_det, wake_frame_det} = ev;
    // Decoder reports each event once, one cycle long
    task pulse(input [1:0] k);
        begin
            @(posedge aclk);
            ev <= 4'h1 << k;
            @(posedge aclk);
            ev <= 4'h0;
        end
    endtask
endmodule

//--- sim/cswm_props.sv
// Assertions on the ports of the selective-wake mode control
`timescale 1ns/100ps
module cswm_props
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire txd,
    input wire rxd,
    input wire bus_tx_dominant,
    input wire wake_frame_det,
    input wire wake_pattern_det,
    input wire err_count_overflow,
    input wire swk_monitor_en,
    input wire can_wake_event
);
    wire any_wake;
    assign any_wake = wake_frame_det | wake_pattern_det | err_count_overflow;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_reset_state;
        $rose(aresetn) |-> rxd && !bus_tx_dominant && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_wake_pulse;
        can_wake_event |=> !can_wake_event;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake event too long");
    property p_wake_cause;
        $rose(can_wake_event) |-> $past(any_wake) || $past(any_wake, 2);
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
    property p_tx_from_txd;
        bus_tx_dominant |-> !$past(txd);
    endproperty
    a_tx_from_txd: assert property (p_tx_from_txd) else $error("bus driven without txd");
    property p_monitor_drop;
        can_wake_event |-> ##[0:2] !swk_monitor_en;
    endproperty
    a_monitor_drop: assert property (p_monitor_drop) else $error("monitor kept after wake");
    property p_write_resp;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response missing");
    property p_read_resp;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read response missing");
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
    property p_upper_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
endmodule

//--- sim/cswm_tb_top.sv
// Register-level testbench for the selective-wake mode control
`timescale 1ns/100ps
`include "cswm_consts.vh"
module cswm_tb_top;
    reg aclk = 1'b0, aresetn = 1'b0, txd = 1'b1, ce = 1'b1;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    reg [31:0] s_axi_wdata = 32'h0, rd;
    reg [2:0] mv;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire rxd, bus_tx_dominant, swk_monitor_en, can_wake_event, bus_rxd;
    wire wake_frame_det, wake_pattern_det, err_count_overflow, bus_silence_det;
    integer failures = 0, checks_done = 0, m;
    always #12.5 aclk = ~aclk;
    cswm_top cswm_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd), .bus_rxd(bus_rxd),
        .rxd(rxd), .bus_tx_dominant(bus_tx_dominant), .wake_frame_det(wake_frame_det),
        .wake_pattern_det(wake_pattern_det), .err_count_overflow(err_count_overflow),
        .bus_silence_det(bus_silence_det), .swk_monitor_en(swk_monitor_en),
        .can_wake_event(can_wake_event));
    cswm_bus_node cswm_bus_node_inst (.aclk(aclk), .bus_rxd(bus_rxd),
        .wake_frame_det(wake_frame_det), .wake_pattern_det(wake_pattern_det),
        .err_count_overflow(err_count_overflow), .bus_silence_det(bus_silence_det));
    task summarize;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                failures = failures + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task axi_wr(input [3:0] a, input [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
            end
            while (s_axi_bvalid !== 1'b1);
            // Ready stays up between calls so no edge sees it dropped and raised at once
            check("bresp", {30'h0, s_axi_bresp}, {30'h0, `CSWM_RESP_OKAY});
        end
    endtask
    task rd_chk(input string nm, input [3:0] a, input [31:0] msk, input [31:0] exp);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
            end
            while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata;
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, `CSWM_RESP_OKAY});
            check(nm, rd & msk, exp);
        end
    endtask
    // Event from the far side, then look for the wake pulse
    task event_wake(input [1:0] k, input exp);
        reg hit;
        begin
            hit = 1'b0;
            cswm_bus_node_inst.pulse(k);
            repeat (4)
            begin
                @(posedge aclk);
                hit = hit | can_wake_event;
            end
            check("wake_event", {31'h0, hit}, {31'h0, exp});
        end
    endtask
    initial
    begin
        repeat (5000) @(posedge aclk);
        failures = failures + 1;
        summarize;
    end
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h0);
        axi_wr(`CSWM_OFS_STAT, 32'h8);
        txd <= 1'b0;
        cswm_bus_node_inst.rx_level <= 1'b0;
        for (m = 0; m < 8; m = m + 1)
        begin
            mv = m[2:0];
            axi_wr(`CSWM_OFS_CAN, {29'h0, mv});
            rd_chk("can", `CSWM_OFS_CAN, 32'h7, {29'h0, mv});
            rd_chk("state", `CSWM_OFS_STATE, 32'h7,
                {29'h0, mv[2] & (mv[1:0] != 2'h0), mv[1:0]});
            check("rxd", {31'h0, rxd}, {31'h0, !mv[1]});
            check("tx", {31'h0, bus_tx_dominant}, {31'h0, &mv[1:0]});
            check("monitor", {31'h0, swk_monitor_en}, {31'h0, mv[2] & (mv[1:0] != 2'h0)});
        end
        // Strobe-less write must leave the mode field alone
        s_axi_wstrb <= 4'h0;
        axi_wr(`CSWM_OFS_CAN, 32'h0);
        s_axi_wstrb <= 4'hF;
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h7);
        rd_chk("stat", `CSWM_OFS_STAT, 32'hB, 32'hA);
        cswm_bus_node_inst.pulse(2'h3);
        rd_chk("silence", `CSWM_OFS_STAT, 32'h4, 32'h4);
        axi_wr(`CSWM_OFS_CAN, 32'h3);
        rd_chk("armed", `CSWM_OFS_STAT, 32'h2, 32'h0);
        axi_wr(`CSWM_OFS_CHIP, 32'h1);
        rd_chk("state", `CSWM_OFS_STATE, 32'h7, 32'h1);
        axi_wr(`CSWM_OFS_CAN, 32'h5);
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h3);
        axi_wr(`CSWM_OFS_CHIP, 32'h0);
        axi_wr(`CSWM_OFS_CAN, 32'h7);
        axi_wr(`CSWM_OFS_CHIP, 32'h1);
        rd_chk("state", `CSWM_OFS_STATE, 32'h7, 32'h7);
        axi_wr(`CSWM_OFS_CHIP, 32'h0);
        cswm_bus_node_inst.rx_level <= 1'b1;
        // Frozen clock enable swallows the frame
        ce <= 1'b0;
        event_wake(2'h0, 1'b0);
        ce <= 1'b1;
        event_wake(2'h0, 1'b1);
        check("rxd", {31'h0, rxd}, 32'h1);
        rd_chk("stat", `CSWM_OFS_STAT, 32'h32, 32'h30);
        axi_wr(`CSWM_OFS_CAN, 32'h3);
        axi_wr(`CSWM_OFS_CAN, 32'h7);
        event_wake(2'h2, 1'b1);
        rd_chk("stat", `CSWM_OFS_STAT, 32'h3, 32'h1);
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h7);
        rd_chk("state", `CSWM_OFS_STATE, 32'h4, 32'h0);
        axi_wr(`CSWM_OFS_CHIP, 32'h2);
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h5);
        rd_chk("state", `CSWM_OFS_STATE, 32'h7, 32'h1);
        cswm_bus_node_inst.pulse(2'h0);
        rd_chk("chip", `CSWM_OFS_CHIP, 32'h3, 32'h2);
        cswm_bus_node_inst.pulse(2'h1);
        rd_chk("chip", `CSWM_OFS_CHIP, 32'h3, 32'h3);
        rd_chk("state", `CSWM_OFS_STATE, 32'h7, 32'h1);
        axi_wr(`CSWM_OFS_CHIP, 32'h0);
        axi_wr(`CSWM_OFS_CAN, 32'h1);
        axi_wr(`CSWM_OFS_STAT, 32'h9);
        axi_wr(`CSWM_OFS_CAN, 32'h5);
        rd_chk("stat", `CSWM_OFS_STAT, 32'hB, 32'hA);
        axi_wr(`CSWM_OFS_CHIP, 32'h2);
        rd_chk("state", `CSWM_OFS_STATE, 32'h7, 32'h5);
        cswm_bus_node_inst.pulse(2'h0);
        rd_chk("chip", `CSWM_OFS_CHIP, 32'h3, 32'h3);
        rd_chk("stat", `CSWM_OFS_STAT, 32'h9, 32'h0);
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h5);
        axi_wr(`CSWM_OFS_CHIP, 32'h0);
        axi_wr(`CSWM_OFS_CAN, 32'h2);
        axi_wr(`CSWM_OFS_CHIP, 32'h2);
        rd_chk("can", `CSWM_OFS_CAN, 32'h7, 32'h1);
        cswm_bus_node_inst.pulse(2'h1);
        axi_wr(`CSWM_OFS_CHIP, 32'h0);
        axi_wr(`CSWM_OFS_CAN, 32'h4);
        axi_wr(`CSWM_OFS_CHIP, 32'h2);
        axi_wr(`CSWM_OFS_STATE, 32'h7);
        rd_chk("state", `CSWM_OFS_STATE, 32'h7, 32'h0);
        cswm_bus_node_inst.pulse(2'h1);
        rd_chk("chip", `CSWM_OFS_CHIP, 32'h3, 32'h2);
        summarize;
    end
endmodule
bind cswm_top cswm_props cswm_props_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .txd(txd), .rxd(rxd), .bus_tx_dominant(bus_tx_dominant), .wake_frame_det(wake_frame_det),
    .wake_pattern_det(wake_pattern_det), .err_count_overflow(err_count_overflow),
    .swk_monitor_en(swk_monitor_en), .can_wake_event(can_wake_event));
